// file: design/ism_map.svh
`ifndef ISM_MAP_SVH
`define ISM_MAP_SVH

// Memory geometry
`define ISM_ADDR_W 14
`define ISM_MEM_DEPTH 16384
`define ISM_ADDR_ZERO 14'h0000
`define ISM_ADDR_ONE 14'h0001

// Bit counter values within one byte slot
`define ISM_BIT_ZERO 4'h0
`define ISM_BIT_ONE 4'h1
`define ISM_BIT_ACK 4'h8
`define ISM_BIT_END 4'h9

// Address word fields, high address byte width and transmit shifter bits
`define ISM_TYPE_MSB 7
`define ISM_TYPE_LSB 4
`define ISM_STRAP_MSB 3
`define ISM_STRAP_LSB 1
`define ISM_RW_BIT 0
`define ISM_HI_MSB 5
`define ISM_TX_NEXT 6
`define ISM_TX_MSB 7

// Reset values
`define ISM_BYTE_ZERO 8'h00
`define ISM_PIN_IDLE 6'h3F

`endif

// file: design/ism_pkg.sv
package ism_pkg;

	// Protocol phases of the serial slave
	typedef enum logic [2:0] {
		st_idle,
		st_devaddr,
		st_addr_hi,
		st_addr_lo,
		st_write,
		st_read
	} ism_state_t;

endpackage

// file: design/ism_sync.sv
`timescale 1ns/1ps
module ism_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// Two flop synchroniser; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// file: design/ism_slave.sv
// Overview of operation
// - Receiver drives ACK low on ninth clock
// - Transmitter releases data line on ninth clock
// - Stop before ACK aborts to standby
// - After NACK release bus, master restarts
// - Compare upper four bits to type code
// - Strap field must equal strap inputs
// - Mismatch means no answer, standby
// - Eighth bit: 0 write, 1 read
// - Two address bytes, high first, each acked
// - Each written data byte is acknowledged
// - Read drives eight bits, awaits master ACK
// - No write delay, address acked at once
// - Protect input high blocks all writes
// - Write bytes increment address, wrap to zero
// - Byte committed right after its ACK
// - Current read returns last address plus one
// - Random read via address then restart
// - Sequential read increments and wraps
// - Start and stop detected while clock high
// - Sample on rise, change on fall
`timescale 1ns/1ps
`include "ism_map.svh"
module ism_slave
	import ism_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b,
	input wire logic addr_strap_0,
	input wire logic addr_strap_1,
	input wire logic addr_strap_2,
	input wire logic write_protect
);

	// Link domain signals
	logic scl_s, sda_s, wp_s;
	logic [2:0] strap_s;
	logic scl_p_q, sda_p_q;
	logic start_w, stop_w, rise_w, fall_w;
	logic ack_slot_w, end_slot_w, rx_state_w, match_w;
	logic rd_req_w, wr_ev_w, cnt_inc_w, nack_w, tx_bit_w, tx_next_w;
	ism_state_t state_q;
	logic [3:0] bit_q;
	logic [7:0] rx_q, tx_q, rdata_l_q;
	logic [`ISM_ADDR_W-1:0] cnt_q, req_addr_q;
	logic oe_b_q, out_q;
	logic req_tgl_q, req_we_q;
	logic [7:0] req_data_q;
	logic ack_s, ack_p_q;

	// Reference domain signals
	logic req_s, req_p_q, ack_tgl_q;
	logic [7:0] rdata_q;
	logic [7:0] mem [0:`ISM_MEM_DEPTH-1];

	// Pins enter the link domain through two flops
	ism_sync #(.W(6), .INIT(`ISM_PIN_IDLE)) u_pin_sync (
		.clk(link_clk),
		.rst_b(rst_b),
		.d({scl_in, sda_in, write_protect, addr_strap_2, addr_strap_1,
			addr_strap_0}),
		.q({scl_s, sda_s, wp_s, strap_s})
	);

	// Completion toggle back into the link domain
	ism_sync #(.W(1), .INIT(1'b0)) u_ack_sync (
		.clk(link_clk),
		.rst_b(rst_b),
		.d(ack_tgl_q),
		.q(ack_s)
	);

	// Request toggle into the reference domain
	ism_sync #(.W(1), .INIT(1'b0)) u_req_sync (
		.clk(ref_clk),
		.rst_b(rst_b),
		.d(req_tgl_q),
		.q(req_s)
	);

	// Previous line levels for edge and condition detection
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Bus events; the clock line is only ever an input
	assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_w = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign rise_w = scl_s && !scl_p_q;
	assign fall_w = !scl_s && scl_p_q;
	assign ack_slot_w = fall_w && (bit_q == `ISM_BIT_ACK);
	assign end_slot_w = fall_w && (bit_q == `ISM_BIT_END);
	assign rx_state_w = (state_q == st_devaddr) || (state_q == st_addr_hi) ||
		(state_q == st_addr_lo) || (state_q == st_write);
	// Type code and strap field, strap 2 first on the wire
	assign match_w = (rx_q[`ISM_TYPE_MSB:`ISM_TYPE_LSB] == DEV_TYPE) &&
		(rx_q[`ISM_STRAP_MSB:`ISM_STRAP_LSB] == strap_s);
	assign nack_w = (state_q == st_read) && rise_w &&
		(bit_q == `ISM_BIT_ACK) && sda_s;
	// Read fetch: after a read address word or a master ACK
	assign rd_req_w = ((state_q == st_devaddr) && ack_slot_w && match_w &&
		rx_q[`ISM_RW_BIT]) || ((state_q == st_read) && rise_w &&
		(bit_q == `ISM_BIT_ACK) && !sda_s);
	assign wr_ev_w = (state_q == st_write) && end_slot_w;
	assign cnt_inc_w = rd_req_w || wr_ev_w;
	assign tx_bit_w = fall_w && (state_q == st_read) &&
		(bit_q >= `ISM_BIT_ONE) && (bit_q < `ISM_BIT_ACK);
	assign tx_next_w = tx_q[`ISM_TX_NEXT];

	// Bit counter: rises counted, ninth fall closes the slot
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_q <= `ISM_BIT_ZERO;
		end else if (start_w || stop_w) begin
			bit_q <= `ISM_BIT_ZERO;
		end else if (rise_w && (bit_q != `ISM_BIT_END)) begin
			bit_q <= bit_q + `ISM_BIT_ONE;
		end else if (end_slot_w) begin
			bit_q <= `ISM_BIT_ZERO;
		end
	end

	// Receive shifter samples on rising clock edges
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_q <= `ISM_BYTE_ZERO;
		end else if (rise_w && (bit_q < `ISM_BIT_ACK)) begin
			rx_q <= {rx_q[6:0], sda_s};
		end
	end

	// Protocol phases
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= st_idle;
		end else if (stop_w) begin
			state_q <= st_idle;
		end else if (start_w) begin
			state_q <= st_devaddr;
		end else if (nack_w) begin
			state_q <= st_idle;
		end else if (ack_slot_w && (state_q == st_devaddr) && !match_w) begin
			state_q <= st_idle;
		end else if (end_slot_w) begin
			case (state_q)
				st_devaddr: begin
					// Direction bit picks the transfer
					state_q <= rx_q[`ISM_RW_BIT] ? st_read : st_addr_hi;
				end
				st_addr_hi: begin
					state_q <= st_addr_lo;
				end
				st_addr_lo: begin
					state_q <= st_write;
				end
				st_write: begin
					state_q <= st_write;
				end
				st_read: begin
					state_q <= st_read;
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// Address counter: loaded by address bytes, steps once per byte
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= `ISM_ADDR_ZERO;
		end else if (ack_slot_w && (state_q == st_addr_hi)) begin
			// Top two bits of the high byte are dropped
			cnt_q <= {rx_q[`ISM_HI_MSB:0], cnt_q[7:0]};
		end else if (ack_slot_w && (state_q == st_addr_lo)) begin
			cnt_q <= {cnt_q[`ISM_ADDR_W-1:8], rx_q};
		end else if (cnt_inc_w) begin
			cnt_q <= cnt_q + `ISM_ADDR_ONE;
		end
	end

	// Requests to the array; address and data held until the next toggle
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_tgl_q <= 1'b0;
			req_we_q <= 1'b0;
			req_addr_q <= `ISM_ADDR_ZERO;
			req_data_q <= `ISM_BYTE_ZERO;
		end else if (wr_ev_w && !wp_s) begin
			// Commit right after the ACK slot
			req_tgl_q <= ~req_tgl_q;
			req_we_q <= 1'b1;
			req_addr_q <= cnt_q;
			req_data_q <= rx_q;
		end else if (rd_req_w) begin
			req_tgl_q <= ~req_tgl_q;
			req_we_q <= 1'b0;
			req_addr_q <= cnt_q;
		end else if (wr_ev_w) begin
			req_we_q <= 1'b0;
		end
	end

	// Returned read byte captured when the completion arrives
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_p_q <= 1'b0;
			rdata_l_q <= `ISM_BYTE_ZERO;
		end else begin
			ack_p_q <= ack_s;
			if (ack_s != ack_p_q) begin
				rdata_l_q <= rdata_q;
			end
		end
	end

	// Transmit shifter loaded at slot end, shifted on falls
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q <= `ISM_BYTE_ZERO;
		end else if (end_slot_w) begin
			tx_q <= rdata_l_q;
		end else if (tx_bit_w) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// Data line enable; set on falling clock edges, released at once on start, stop or NACK
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			oe_b_q <= 1'b1;
		end else if (start_w || stop_w || nack_w) begin
			oe_b_q <= 1'b1;
		end else if (ack_slot_w) begin
			// ACK for accepted bytes, release when sending
			oe_b_q <= !(rx_state_w && ((state_q != st_devaddr) || match_w));
		end else if (end_slot_w) begin
			if ((state_q == st_read) ||
				((state_q == st_devaddr) && rx_q[`ISM_RW_BIT])) begin
				oe_b_q <= rdata_l_q[`ISM_TX_MSB];
			end else begin
				oe_b_q <= 1'b1;
			end
		end else if (tx_bit_w) begin
			oe_b_q <= tx_next_w;
		end
	end

	// Open drain: the data output level is always low
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 1'b0;
		end else begin
			out_q <= 1'b0;
		end
	end

	assign sda_oe_b = oe_b_q;
	assign sda_out = out_q;

	// Array side: serve one request per toggle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_p_q <= 1'b0;
			ack_tgl_q <= 1'b0;
			rdata_q <= `ISM_BYTE_ZERO;
		end else begin
			req_p_q <= req_s;
			if (req_s != req_p_q) begin
				rdata_q <= mem[req_addr_q];
				ack_tgl_q <= ~ack_tgl_q;
			end
		end
	end

	// Storage array, no reset: contents persist
	always_ff @(posedge ref_clk) begin
		if ((req_s != req_p_q) && req_we_q) begin
			mem[req_addr_q] <= req_data_q;
		end
	end

	// Checks on the link side
	ack_drive_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(ack_slot_w && ((state_q == st_addr_hi) || (state_q == st_addr_lo) ||
		(state_q == st_write))) |=> !oe_b_q ##1 !oe_b_q)
		else $error("byte not acknowledged");
	dev_ack_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(ack_slot_w && (state_q == st_devaddr) && match_w) |=> !oe_b_q)
		else $error("matching address word not acknowledged");
	no_match_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(ack_slot_w && (state_q == st_devaddr) && !match_w) |=>
		(state_q == st_idle) && oe_b_q)
		else $error("mismatched address answered");
	stop_idle_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		stop_w |=> (state_q == st_idle) && oe_b_q)
		else $error("stop did not return to standby");
	tx_release_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(ack_slot_w && (state_q == st_read)) |=> oe_b_q)
		else $error("line held in master ACK slot");
	nack_release_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		nack_w |=> (state_q == st_idle) && oe_b_q && $stable(req_tgl_q))
		else $error("bus not released after NACK");
	wr_commit_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(wr_ev_w && !wp_s) |=> req_we_q && (req_tgl_q != $past(req_tgl_q)) &&
		(req_addr_q == $past(cnt_q)))
		else $error("written byte not committed");
	wp_block_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		(wr_ev_w && wp_s) |=> !req_we_q && $stable(req_tgl_q))
		else $error("write passed while protected");
	cnt_step_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		cnt_inc_w |=> (cnt_q == $past(cnt_q) + `ISM_ADDR_ONE))
		else $error("address counter did not step");
	rd_bit_a: assert property (@(posedge link_clk) disable iff (!rst_b)
		tx_bit_w |=> (oe_b_q == $past(tx_next_w)))
		else $error("wrong read bit on line");

	wr_byte_c: cover property (@(posedge link_clk) disable iff (!rst_b)
		wr_ev_w && !wp_s);
	rd_seq_c: cover property (@(posedge link_clk) disable iff (!rst_b)
		rd_req_w && (state_q == st_read));
	nack_c: cover property (@(posedge link_clk) disable iff (!rst_b)
		nack_w ##[1:200] stop_w);
	no_match_c: cover property (@(posedge link_clk) disable iff (!rst_b)
		ack_slot_w && (state_q == st_devaddr) && !match_w);

endmodule

// file: bench/ism_master.sv
`timescale 1ns/1ps
module ism_master (
	input wire logic clk,
	input wire logic dev_out,
	input wire logic dev_oe_b,
	output logic scl,
	output logic sda
);
	logic drv_b = 1'b1;

	// Open-drain data line with pull-up; released means high
	assign sda = drv_b & (dev_oe_b | dev_out);

	// Master alone owns the clock, idle high between frames
	initial scl = 1'b1;

	// Quarter bit time, 125 ns
	task automatic q();
		repeat (25) @(negedge clk);
	endtask

	// Start or repeated start: data falls while clock high
	task automatic start();
		drv_b = 1'b1;
		q();
		scl = 1'b1;
		q();
		drv_b = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask

	// Stop: data rises while clock high
	task automatic stop();
		drv_b = 1'b0;
		q();
		scl = 1'b1;
		q();
		drv_b = 1'b1;
		q();
	endtask

	// One clock slot; data changes only while clock low
	task automatic xfer(input logic b, output logic r);
		drv_b = b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
		q();
	endtask

	// Byte out MSB first, then release for the ACK slot
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(b[i], r);
		end
		xfer(1'b1, r);
		ack = ~r;
	endtask

	// Byte in, then ACK low or NACK high
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, d[i]);
		end
		xfer(~ack, r);
	endtask
endmodule

// file: bench/tb_i2c_slave_serial_memory_access.sv
`timescale 1ns/1ps
module tb_i2c_slave_serial_memory_access;
	localparam logic [3:0] TYP = 4'h6; // Arbitrary type code
	localparam logic [2:0] STR = 3'h5;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp = 1'b0;
	logic scl, sda, sda_out, sda_oe_b, k;
	logic [7:0] d;
	int mismatches = 0;
	int checks_done = 0;

	// Array clock 5 ns
	always #2.5 ref_clk = ~ref_clk;

	// Link clock 6 ns, phase unrelated to the array clock
	always #3 link_clk = ~link_clk;

	ism_slave #(.DEV_TYPE(TYP)) DUT (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.link_clk(link_clk),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_b(sda_oe_b),
		.addr_strap_0(STR[0]),
		.addr_strap_1(STR[1]),
		.addr_strap_2(STR[2]),
		.write_protect(wp)
	);

	ism_master M (
		.clk(ref_clk),
		.dev_out(sda_out),
		.dev_oe_b(sda_oe_b),
		.scl(scl),
		.sda(sda)
	);

	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Write-direction address word and two address bytes
	task automatic setaddr(input logic [13:0] a);
		M.start();
		M.wbyte({TYP, STR, 1'b0}, k);
		chk(k, 1);
		M.wbyte({2'b00, a[13:8]}, k);
		chk(k, 1);
		M.wbyte(a[7:0], k);
		chk(k, 1);
	endtask

	// Random read of one byte
	task automatic rd1(input logic [13:0] a, input logic [7:0] e);
		setaddr(a);
		M.start();
		M.wbyte({TYP, STR, 1'b1}, k);
		chk(k, 1);
		M.rbyte(1'b0, d);
		chk(d, e);
		M.stop();
	endtask

	// Page write crossing the top address
	task automatic t_write();
		setaddr(14'h3FFF);
		for (int i = 0; i < 3; i++) begin
			M.wbyte(8'hC0 + i[7:0], k);
			chk(k, 1);
		end
		M.stop();
	endtask

	// Sequential read with wrap, then current-address read
	task automatic t_read();
		setaddr(14'h3FFF);
		M.start();
		M.wbyte({TYP, STR, 1'b1}, k);
		chk(k, 1);
		M.rbyte(1'b1, d);
		chk(d, 8'hC0);
		M.rbyte(1'b0, d);
		chk(d, 8'hC1);
		M.stop();
		M.start();
		M.wbyte({TYP, STR, 1'b1}, k);
		chk(k, 1);
		M.rbyte(1'b0, d);
		chk(d, 8'hC2);
		M.stop();
	endtask

	// Wrong type code and wrong strap field get no answer
	task automatic t_nomatch();
		M.start();
		M.wbyte({TYP ^ 4'h8, STR, 1'b0}, k);
		chk(k, 0);
		M.stop();
		M.start();
		M.wbyte({TYP, STR ^ 3'h4, 1'b1}, k);
		chk(k, 0);
		M.stop();
		rd1(14'h0001, 8'hC2);
	endtask

	// Protected write is acked but leaves the array alone
	task automatic t_wp();
		@(negedge ref_clk) wp = 1'b1;
		setaddr(14'h0000);
		M.wbyte(8'h55, k);
		chk(k, 1);
		M.stop();
		rd1(14'h0000, 8'hC1);
		@(negedge ref_clk) wp = 1'b0;
	endtask

	// Stop in mid data byte aborts the write
	task automatic t_abort();
		setaddr(14'h0001);
		for (int i = 0; i < 4; i++) begin
			M.xfer(1'b0, k);
		end
		M.stop();
		rd1(14'h0001, 8'hC2);
	endtask

	// Watchdog over the whole run
	initial begin
		repeat (90000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (16) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (10) @(negedge ref_clk);
		t_write();
		t_read();
		t_nomatch();
		t_wp();
		t_abort();
		conclude();
	end
endmodule
